// ==== shared/pwmg_pkg.sv ====
// Purpose: Constants and types shared by the two-channel PWM generator
// Assumes: AHB-Lite register access, one word per register
// Notes:   Channel n registers sit at n * PWMG_CH_STRIDE
package pwmg_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int PWMG_NCH   = 2;
  localparam int PWMG_CNT_W = 16;
  localparam int PWMG_PRE_W = 12;

  // ------------------------------------------------------------------
  // Register map (byte offsets)
  // ------------------------------------------------------------------
  localparam logic [7:0] PWMG_CH_STRIDE  = 8'h10;
  localparam logic [3:0] PWMG_OFF_CTRL   = 4'h0;
  localparam logic [3:0] PWMG_OFF_PERIOD = 4'h4;
  localparam logic [3:0] PWMG_OFF_DUTY   = 4'h8;
  localparam logic [3:0] PWMG_OFF_STATUS = 4'hC;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int PWMG_CTRL_EN    = 0;
  localparam int PWMG_CTRL_PULSE = 1;
  localparam int PWMG_CTRL_POL   = 2;
  localparam int PWMG_CTRL_START = 3;
  localparam int PWMG_CTRL_PRE_L = 16;
  localparam int PWMG_STAT_OUT   = 16;
  localparam int PWMG_STAT_BUSY  = 17;

  // ------------------------------------------------------------------
  // Reset values and bus codes
  // ------------------------------------------------------------------
  localparam logic [PWMG_CNT_W-1:0] PWMG_PERIOD_RST = 16'hFFFF;
  localparam logic [PWMG_CNT_W-1:0] PWMG_DUTY_RST   = 16'h8000;
  localparam logic [PWMG_PRE_W-1:0] PWMG_PRE_RST    = 12'h000;
  localparam logic [1:0]            PWMG_HTRANS_NSQ = 2'h2;
  localparam logic                  PWMG_HRESP_OKAY = 1'h0;

  typedef enum logic {PWMG_ST_IDLE, PWMG_ST_RUN} pwmg_state_e;

endpackage

// ==== rtl/pwmg_channel.sv ====
// Purpose: One PWM channel: prescaler, 16-bit up counter, output stage
// Assumes: Control inputs come from registers on the same clock
// Notes:   Output is registered, so it lags the counter by one cycle
`timescale 1ns/100ps
module pwmg_channel
  import pwmg_pkg::*;
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // Configuration
  input  wire logic                  en,
  input  wire logic                  pulse_mode,
  input  wire logic                  act_high,
  input  wire logic [PWMG_PRE_W-1:0] presc,
  input  wire logic [PWMG_CNT_W-1:0] period,
  input  wire logic [PWMG_CNT_W-1:0] duty,
  input  wire logic                  start,
  // State
  output logic                       tick,
  output logic                       busy,
  output logic      [PWMG_CNT_W-1:0] count,
  output logic                       channel_wave_output
);

  pwmg_state_e             state_q;
  logic [PWMG_PRE_W-1:0]   pre_q;
  logic [PWMG_CNT_W-1:0]   cnt_q;
  logic                    wave_q;
  logic                    at_end;

  assign busy   = (state_q == PWMG_ST_RUN);
  // Compare with >= so a divider lowered mid-run ticks at once
  // instead of running the prescaler round its full 4096 range
  assign tick   = busy && (pre_q >= presc);
  assign at_end = tick && (cnt_q == period);
  assign count  = cnt_q;
  assign channel_wave_output = wave_q;

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= PWMG_ST_IDLE;
    end else begin
      unique case (state_q)
        PWMG_ST_IDLE: begin
          if (en && (!pulse_mode || start)) begin
            state_q <= PWMG_ST_RUN;
          end
        end
        PWMG_ST_RUN: begin
          // A pulse lasts exactly one count period
          if (!en || (pulse_mode && at_end)) begin
            state_q <= PWMG_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Prescaler: divide by presc + 1, 1 to 4096
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= '0;
    end else if (!busy || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (!busy || at_end) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Output: active from count zero until the duty value
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_q <= 1'b0;
    end else begin
      // Inactive level follows polarity even when idle
      wave_q <= (busy && (cnt_q < duty)) ? act_high : !act_high;
    end
  end

endmodule

// ==== rtl/pwmg_top.sv ====
// Purpose: Two-channel PWM generator with AHB-Lite register slave
// Assumes: hclk is the counting source clock; single word transfers
// Notes:   Reads take one wait state; writes take none
`timescale 1ns/100ps

module pwmg_top
  import pwmg_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Modulated outputs
  output logic             first_channel_output,
  output logic             second_channel_output
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic                  en_q     [PWMG_NCH];
  logic                  pulse_q  [PWMG_NCH];
  logic                  pol_q    [PWMG_NCH];
  logic                  start_q  [PWMG_NCH];
  logic [PWMG_PRE_W-1:0] pre_q    [PWMG_NCH];
  logic [PWMG_CNT_W-1:0] period_q [PWMG_NCH];
  logic [PWMG_CNT_W-1:0] duty_q   [PWMG_NCH];
  logic                  tick     [PWMG_NCH];
  logic                  busy     [PWMG_NCH];
  logic [PWMG_CNT_W-1:0] count    [PWMG_NCH];
  logic                  wave     [PWMG_NCH];

  logic                  wr_q;
  logic                  rd_q;
  logic [7:0]            addr_q;
  logic [31:0]           rdata_q;
  logic                  take;

  // Address decode: hit for a channel and offset
  function automatic logic reg_hit(input logic [7:0] a, input int ch,
                                   input logic [3:0] off);
    reg_hit = (a == 8'(ch * PWMG_CH_STRIDE + off));
  endfunction

  // ------------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------------
  assign take      = hsel && hready && (htrans == PWMG_HTRANS_NSQ);
  assign hreadyout = !rd_q;
  assign hresp     = PWMG_HRESP_OKAY;
  assign hrdata    = rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= '0;
    end else begin
      // Read waits a cycle so a write just before it is seen
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (rd_q) begin
      rdata_q <= '0;
      for (int c = 0; c < PWMG_NCH; c++) begin
        if (reg_hit(addr_q, c, PWMG_OFF_CTRL)) begin
          rdata_q[PWMG_CTRL_EN]    <= en_q[c];
          rdata_q[PWMG_CTRL_PULSE] <= pulse_q[c];
          rdata_q[PWMG_CTRL_POL]   <= pol_q[c];
          rdata_q[PWMG_CTRL_PRE_L +: PWMG_PRE_W] <= pre_q[c];
        end
        if (reg_hit(addr_q, c, PWMG_OFF_PERIOD)) begin
          rdata_q[PWMG_CNT_W-1:0] <= period_q[c];
        end
        if (reg_hit(addr_q, c, PWMG_OFF_DUTY)) begin
          rdata_q[PWMG_CNT_W-1:0] <= duty_q[c];
        end
        if (reg_hit(addr_q, c, PWMG_OFF_STATUS)) begin
          rdata_q[PWMG_CNT_W-1:0]  <= count[c];
          rdata_q[PWMG_STAT_OUT]   <= wave[c];
          rdata_q[PWMG_STAT_BUSY]  <= busy[c];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Per-channel registers and generator
  // ------------------------------------------------------------------
  for (genvar c = 0; c < PWMG_NCH; c++) begin : g_ch
    logic wr_ctrl;
    logic [PWMG_PRE_W:0] gap_q;
    logic                fresh_q;

    assign wr_ctrl = wr_q && reg_hit(addr_q, c, PWMG_OFF_CTRL);

    // Each channel decodes only its own addresses
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        en_q[c]    <= 1'b0;
        pulse_q[c] <= 1'b0;
        pol_q[c]   <= 1'b1;
        pre_q[c]   <= PWMG_PRE_RST;
      end else if (wr_ctrl) begin
        en_q[c]    <= hwdata[PWMG_CTRL_EN];
        pulse_q[c] <= hwdata[PWMG_CTRL_PULSE];
        pol_q[c]   <= hwdata[PWMG_CTRL_POL];
        pre_q[c]   <= hwdata[PWMG_CTRL_PRE_L +: PWMG_PRE_W];
      end
    end

    // Start is a one-cycle strobe and reads back as zero
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        start_q[c] <= 1'b0;
      end else begin
        start_q[c] <= wr_ctrl && hwdata[PWMG_CTRL_START];
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        period_q[c] <= PWMG_PERIOD_RST;
        duty_q[c]   <= PWMG_DUTY_RST;
      end else begin
        if (wr_q && reg_hit(addr_q, c, PWMG_OFF_PERIOD)) begin
          period_q[c] <= hwdata[PWMG_CNT_W-1:0];
        end
        if (wr_q && reg_hit(addr_q, c, PWMG_OFF_DUTY)) begin
          duty_q[c] <= hwdata[PWMG_CNT_W-1:0];
        end
      end
    end

    pwmg_channel u_ch (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .en                  (en_q[c]),
      .pulse_mode          (pulse_q[c]),
      .act_high            (pol_q[c]),
      .presc               (pre_q[c]),
      .period              (period_q[c]),
      .duty                (duty_q[c]),
      .start               (start_q[c]),
      .tick                (tick[c]),
      .busy                (busy[c]),
      .count               (count[c]),
      .channel_wave_output (wave[c])
    );

    // Helper: cycles since the last tick, for checking the divider
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        gap_q <= '0;
      end else if (!busy[c] || tick[c] || wr_ctrl) begin
        gap_q <= '0;
      end else begin
        gap_q <= gap_q + 1'b1;
      end
    end

    // Helper: the first tick after a control write still follows the
    // old divider phase, so only later ticks are held to the spacing
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fresh_q <= 1'b0;
      end else if (wr_ctrl) begin
        fresh_q <= 1'b1;
      end else if (tick[c]) begin
        fresh_q <= 1'b0;
      end
    end

    sequence s_pulse_last;
      busy[c] && pulse_q[c] && en_q[c] && tick[c]
        && (count[c] == period_q[c]);
    endsequence

    property p_count_up;
      @(posedge hclk) disable iff (!hresetn)
      busy[c] && en_q[c] && tick[c] && (count[c] != period_q[c])
        |=> (count[c] == PWMG_CNT_W'($past(count[c]) + 1'b1));
    endproperty
    a_count_up: assert property (p_count_up)
      else $error("counter did not step up on tick");

    property p_wrap;
      @(posedge hclk) disable iff (!hresetn)
      busy[c] && en_q[c] && tick[c] && (count[c] == period_q[c])
        |=> (count[c] == '0);
    endproperty
    a_wrap: assert property (p_wrap)
      else $error("counter did not reset at period");

    property p_start_active;
      @(posedge hclk) disable iff (!hresetn)
      busy[c] && en_q[c] && (count[c] == '0) && (duty_q[c] != '0)
        |=> (wave[c] == $past(pol_q[c]));
    endproperty
    a_start_active: assert property (p_start_active)
      else $error("output not active at period start");

    property p_divider;
      @(posedge hclk) disable iff (!hresetn)
      tick[c] && $past(busy[c]) && !$past(tick[c]) && !$past(wr_ctrl)
        && !fresh_q
        |-> (gap_q == (PWMG_PRE_W+1)'(pre_q[c]));
    endproperty
    a_divider: assert property (p_divider)
      else $error("tick spacing differs from prescaler");

    property p_cycle_runs;
      @(posedge hclk) disable iff (!hresetn)
      busy[c] && en_q[c] && !pulse_q[c] && !wr_ctrl |=> busy[c];
    endproperty
    a_cycle_runs: assert property (p_cycle_runs)
      else $error("cycle mode stopped while enabled");

    property p_pulse_once;
      @(posedge hclk) disable iff (!hresetn)
      s_pulse_last ##1 (!wr_ctrl && !start_q[c])
        |-> !busy[c] ##1 (wave[c] == !$past(pol_q[c], 2));
    endproperty
    a_pulse_once: assert property (p_pulse_once)
      else $error("pulse did not end after one period");

    property p_duty_end;
      @(posedge hclk) disable iff (!hresetn)
      busy[c] && (count[c] >= duty_q[c])
        |=> (wave[c] == !$past(pol_q[c]));
    endproperty
    a_duty_end: assert property (p_duty_end)
      else $error("output active past duty value");
  end

  assign first_channel_output  = wave[0];
  assign second_channel_output = wave[1];

  property p_chan_indep;
    @(posedge hclk) disable iff (!hresetn)
    wr_q && (addr_q[7:4] == 4'h1) |=> $stable(en_q[0]) && $stable(pol_q[0])
      && $stable(period_q[0]) && $stable(duty_q[0]);
  endproperty
  a_chan_indep: assert property (p_chan_indep)
    else $error("channel 1 write disturbed channel 0");

endmodule

// ==== testbench/pwmg_load_model.sv ====
// Purpose: Load on the two modulated outputs; measures level run lengths
// Assumes: Outputs are sampled on hclk, like a synchronous load would
// Notes:   Observer only; it never drives back into the device
`timescale 1ns/100ps
module pwmg_load_model (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Observed waves, bit c is channel c
  input  wire logic [1:0]       wave,
  // Run lengths in hclk cycles, and counts of level changes
  output logic      [1:0][15:0] hi_len,
  output logic      [1:0][15:0] lo_len,
  output logic      [1:0][15:0] edges
);
  logic [1:0]       prev_q;
  logic [1:0][15:0] run_q;

  // ------------------------------------------------------------------
  // Run measurement
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= '0;
      run_q  <= '0;
      hi_len <= '0;
      lo_len <= '0;
      edges  <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        // Case inequality so an unknown level counts as a change
        if (wave[c] !== prev_q[c]) begin
          if (prev_q[c]) begin
            hi_len[c] <= run_q[c];
          end else begin
            lo_len[c] <= run_q[c];
          end
          run_q[c] <= 16'h0001;
          edges[c] <= edges[c] + 16'h0001;
        end else begin
          run_q[c] <= run_q[c] + 16'h0001;
        end
        prev_q[c] <= wave[c];
      end
    end
  end
endmodule

// ==== testbench/pwmg_top_tb.sv ====
// Purpose: Self-checking bench for the two-channel PWM generator
// Assumes: One AHB-Lite master; hready is the slave's hreadyout
// Notes:   Waits on the bus are bounded; a watchdog ends a hang
`timescale 1ns/100ps
module pwmg_top_tb;
  import pwmg_pkg::*;
  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic [1:0]       wave;
  logic [1:0][15:0] hi_len;
  logic [1:0][15:0] lo_len;
  logic [1:0][15:0] edges;
  logic [31:0]      rd;
  logic [31:0]      rd2;
  logic [15:0]      snap;
  int               err_total;
  int               compares;

  pwmg_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .first_channel_output(wave[0]),
    .second_channel_output(wave[1]));
  pwmg_load_model load_u (.hclk(hclk), .hresetn(hresetn), .wave(wave),
    .hi_len(hi_len), .lo_len(lo_len), .edges(edges));

  // ------------------------------------------------------------------
  // Bus tasks and checks
  // ------------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= PWMG_HTRANS_NSQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  function automatic logic [31:0] reg_a(input int c, input logic [3:0] o);
    return 32'(c) * 32'(PWMG_CH_STRIDE) + 32'(o);
  endfunction

  function automatic logic [31:0] ctl(input logic en, input logic pulse,
      input logic pol, input logic start, input logic [11:0] pre);
    return {4'h0, pre, 12'h000, start, pol, pulse, en};
  endfunction

  task automatic wr(input int c, input logic [3:0] o, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, reg_a(c, o), d, q);
  endtask

  task automatic rdr(input int c, input logic [3:0] o);
    xfer(1'b0, reg_a(c, o), 32'h0, rd);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    #(20000 * 50);
    err_total++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    err_total = 0;
    compares  = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, read-only status and a silent unmapped place
    for (int c = 0; c < PWMG_NCH; c++) begin
      wr(c, PWMG_OFF_STATUS, 32'hFFFF_FFFF);
      rdr(c, PWMG_OFF_CTRL);   chk(rd, 32'h0000_0004);
      rdr(c, PWMG_OFF_PERIOD); chk(rd, 32'h0000_FFFF);
      rdr(c, PWMG_OFF_DUTY);   chk(rd, 32'h0000_8000);
      rdr(c, PWMG_OFF_STATUS); chk(rd, 32'h0000_0000);
    end
    xfer(1'b1, 32'h0000_0020, 32'hA5A5_A5A5, rd);
    xfer(1'b0, 32'h0000_0020, 32'h0, rd); chk(rd, 32'h0);
    chk({31'h0, hresp}, {31'h0, PWMG_HRESP_OKAY});
    // Both channels in cycle mode, different periods and polarity
    wr(0, PWMG_OFF_PERIOD, 32'h2);
    wr(0, PWMG_OFF_DUTY, 32'h1);
    wr(1, PWMG_OFF_PERIOD, 32'h4);
    wr(1, PWMG_OFF_DUTY, 32'h2);
    wr(0, PWMG_OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b0, 12'h000));
    wr(1, PWMG_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 12'h003));
    repeat (100) @(posedge hclk);
    chk(32'(hi_len[0]), 32'd1);
    chk(32'(lo_len[0]), 32'd2);
    chk(32'(lo_len[1]), 32'd8);
    chk(32'(hi_len[1]), 32'd12);
    // Counter steps upward with a long period
    wr(1, PWMG_OFF_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b0, 12'h000));
    wr(1, PWMG_OFF_PERIOD, 32'hFFFF);
    wr(1, PWMG_OFF_DUTY, 32'h0);
    rdr(1, PWMG_OFF_STATUS);
    rd2 = rd;
    rdr(1, PWMG_OFF_STATUS);
    chk({31'h0, rd[15:0] > rd2[15:0]}, 32'h1);
    // Zero duty keeps an active-high output low
    snap = edges[1];
    repeat (20) @(posedge hclk);
    chk(32'(edges[1] - snap), 32'h0);
    chk({31'h0, wave[1]}, 32'h0);
    // Disable clears the counter and parks the output inactive
    wr(0, PWMG_OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0, 12'h000));
    // Run state drops one edge after the write, the counter one later
    repeat (2) @(posedge hclk);
    rdr(0, PWMG_OFF_STATUS); chk(rd, 32'h0);
    // Single pulse in both polarities, one active run then idle
    wr(0, PWMG_OFF_PERIOD, 32'h3);
    wr(0, PWMG_OFF_DUTY, 32'h2);
    for (int p = 0; p < 2; p++) begin
      wr(0, PWMG_OFF_CTRL, ctl(1'b1, 1'b1, p[0], 1'b0, 12'h000));
      repeat (4) @(posedge hclk);
      snap = edges[0];
      wr(0, PWMG_OFF_CTRL, ctl(1'b1, 1'b1, p[0], 1'b1, 12'h000));
      for (int n = 0; n < 20; n++) begin
        rdr(0, PWMG_OFF_STATUS);
        if (rd[PWMG_STAT_BUSY] === 1'b0) break;
      end
      repeat (10) @(posedge hclk);
      chk(32'(edges[0] - snap), 32'd2);
      chk(32'(p ? hi_len[0] : lo_len[0]), 32'd2);
      rdr(0, PWMG_OFF_STATUS);
      chk(rd, {15'h0, ~p[0], 16'h0});
    end
    wrap_up();
  end
endmodule
